// ---- include/iim_pkg.sv ----
/*
 * iim_pkg: constants, bit positions and carriers of the interrupt
 * mask and raw status block of the two-wire bus controller.
 * assumes: imported by the core, the flag cell and the bench.
 */
`default_nettype none
package iim_pkg;
    // register byte addresses as seen by the processor
    localparam logic [31:0] MASK_ADDR   = 32'h5000_1330;
    localparam logic [31:0] RAW_ADDR    = 32'h5000_1334;
    localparam int          DATA_W      = 16;
    localparam int          NUM_FLAGS   = 12;
    // raw and mask bit positions
    localparam int          B_RX_UNDER  = 0;
    localparam int          B_RX_OVER   = 1;
    localparam int          B_RX_FULL   = 2;
    localparam int          B_TX_OVER   = 3;
    localparam int          B_TX_EMPTY  = 4;
    localparam int          B_RD_REQ    = 5;
    localparam int          B_TX_ABORT  = 6;
    localparam int          B_SLV_DONE  = 7;
    localparam int          B_ACTIVITY  = 8;
    localparam int          B_STOP      = 9;
    localparam int          B_START     = 10;
    localparam int          B_BCAST     = 11;
    // reset values and writable bits
    localparam logic [15:0] MASK_RST    = 16'h08ff;
    localparam logic [15:0] MASK_WBITS  = 16'h0fff;
    localparam logic [15:0] RDATA_RST   = 16'h0000;
    // buffer depths and threshold field width
    localparam int          TX_DEPTH    = 32;
    localparam int          RX_DEPTH    = 32;
    localparam int          THR_W       = 5;

    // bus and buffer events from the controller core
    typedef struct packed {
        logic bcast_ack;    // general call address acknowledged
        logic start_seen;   // start or repeated start on the bus
        logic stop_seen;    // stop on the bus
        logic active;       // controller busy on the bus (level)
        logic slv_tx_nack;  // master did not ack our byte as slave tx
        logic tx_abort;     // transmit abort
        logic rd_req;       // remote master addressed us for read
        logic rx_push;      // byte received from the bus
        logic dc_write;     // processor writes the data-command register
        logic dc_read;      // processor reads the data-command register
    } iim_evt_s;

    // read strobes of the clear registers
    typedef struct packed {
        logic broadcast_clr;
        logic activity_clr;
        logic combined_clr;
        logic abort_clr;
        logic rd_req_clr;
    } iim_clr_s;
endpackage : iim_pkg
`default_nettype wire

// ---- core/iim_flag.sv ----
/*
 * iim_flag: one status flag, set wins over clear.
 * assumes: set and clr are synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module iim_flag (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output var  logic q_o
);
    import iim_pkg::*;

    logic q_q;
    logic q_d;

    // an event in the clearing cycle is kept
    always_comb begin
        q_d = q_q;
        if (set_i) begin
            q_d = 1'b1;
        end else if (clr_i) begin
            q_d = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_q <= 1'b0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q_o = q_q;
endmodule : iim_flag
`default_nettype wire

// ---- core/iim_core.sv ----
/*
 * iim_core: raw interrupt status, mask register, masked status and
 * interrupt request of the two-wire bus controller, plus the buffer
 * gating that those flags imply.
 * assumes: a simple register port at printed byte addresses, events
 * and clear-register read strobes as one-cycle pulses on CLK_I.
 */
// Notes on behaviour
// R1: mask bit gates same status bit; resets 0x8ff; bits 15:12 reserved.
// R2: general call flag set only when general call address acknowledged.
// R3: general call flag stays until disable or broadcast clear read.
// R4: bytes after acknowledged general call go into receive buffer.
// R5: start flag set on any start or repeated start.
// R6: stop flag set on any stop.
// R7: activity flag sticky; cleared by disable, clear reads, or reset.
// R8: slave transmitter sets done flag on master's missing acknowledge.
// R9: transmit abort flag set when transmit actions cannot complete.
// R10: transmit buffer flushed while abort flag set, until abort clear read.
// R11: read request sets flag and holds clock line low until serviced.
// R12: processor answers read request by writing the data-command register.
// R13: read request flag cleared right after its clear register read.
// R14: transmit empty flag tracks level at or below threshold.
// R15: while disabled transmit buffer flushed; empty flag follows activity.
// R16: transmit overflow on write to full buffer; clears disabled and idle.
// R17: receive full flag tracks level at or above threshold; clears disabled.
// R18: receive overflow on byte to full buffer; byte acknowledged, dropped.
// R19: receive underflow on data-command read of empty buffer.
// R20: masked status is raw and mask; interrupt is OR of it.
`timescale 1ns/1ps
`default_nettype none
module iim_core #(
    parameter int TX_DEPTH = iim_pkg::TX_DEPTH,
    parameter int RX_DEPTH = iim_pkg::RX_DEPTH,
    parameter int TX_LW    = $clog2(TX_DEPTH + 1),
    parameter int RX_LW    = $clog2(RX_DEPTH + 1)
) (
    input  wire logic                         CLK_I,
    input  wire logic                         RST_B_I,
    input  wire logic [31:0]                  REG_ADDR_I,
    input  wire logic                         REG_WR_I,
    input  wire logic                         REG_RD_I,
    input  wire logic [iim_pkg::DATA_W-1:0]   REG_WDATA_I,
    output var  logic [iim_pkg::DATA_W-1:0]   REG_RDATA_O,
    input  wire iim_pkg::iim_evt_s            EVT_I,
    input  wire iim_pkg::iim_clr_s            CLR_I,
    input  wire logic                         CTRL_ENABLED_I,
    input  wire logic                         FSM_ACTIVE_I,
    input  wire logic [TX_LW-1:0]             TX_LEVEL_I,
    input  wire logic [iim_pkg::THR_W-1:0]    TX_THRESHOLD_I,
    input  wire logic [RX_LW-1:0]             RX_LEVEL_I,
    input  wire logic [iim_pkg::THR_W-1:0]    RX_THRESHOLD_I,
    output var  logic [iim_pkg::NUM_FLAGS-1:0] RAW_STATUS_O,
    output var  logic [iim_pkg::NUM_FLAGS-1:0] MASKED_STATUS_O,
    output var  logic                         IRQ_O,
    output var  logic                         TX_FLUSH_O,
    output var  logic                         TX_WRITE_O,
    output var  logic                         RX_WRITE_O,
    output var  logic                         SCL_HOLD_LOW_O
);
    import iim_pkg::*;

    // depths beyond the threshold field cannot be served
    if (TX_DEPTH < 1 || TX_DEPTH > 32 || RX_DEPTH < 1 || RX_DEPTH > 32) begin : g_chk
        $error("iim_core: buffer depth must be 1 to 32");
    end

    logic [DATA_W-1:0]    mask_q;
    logic [DATA_W-1:0]    mask_d;
    logic [DATA_W-1:0]    rdata_q;
    logic [DATA_W-1:0]    rdata_d;
    logic                 hold_q;
    logic                 hold_d;
    logic [NUM_FLAGS-1:0] set_c;
    logic [NUM_FLAGS-1:0] clr_c;
    logic [NUM_FLAGS-1:0] raw;
    logic [TX_LW-1:0]     tx_thr_c;
    logic [RX_LW-1:0]     rx_thr_c;
    logic                 tx_full_c;
    logic                 rx_full_c;
    logic                 tx_low_c;
    logic                 rx_high_c;
    logic                 off_c;
    logic                 off_idle_c;

    // oversized thresholds clamp to the buffer depth
    always_comb begin
        tx_thr_c = (int'(TX_THRESHOLD_I) > TX_DEPTH) ? TX_LW'(TX_DEPTH)
                                                     : TX_LW'(TX_THRESHOLD_I);
        rx_thr_c = (int'(RX_THRESHOLD_I) > RX_DEPTH - 1) ? RX_LW'(RX_DEPTH - 1)
                                                         : RX_LW'(RX_THRESHOLD_I);
    end

    // buffer conditions and enable states
    assign tx_full_c  = (TX_LEVEL_I == TX_LW'(TX_DEPTH));
    assign rx_full_c  = (RX_LEVEL_I == RX_LW'(RX_DEPTH));
    assign tx_low_c   = (TX_LEVEL_I <= tx_thr_c);
    // value 0 means one entry
    assign rx_high_c  = (RX_LEVEL_I > rx_thr_c);
    assign off_c      = !CTRL_ENABLED_I;
    assign off_idle_c = off_c && !FSM_ACTIVE_I;

    // set and clear terms of every status flag
    always_comb begin
        set_c = '0;
        clr_c = '0;
        // R2: acknowledged general call
        set_c[B_BCAST]    = EVT_I.bcast_ack;
        // R3: broadcast clear or disable
        clr_c[B_BCAST]    = CLR_I.broadcast_clr || CLR_I.combined_clr || off_c;
        // R5: start seen
        set_c[B_START]    = EVT_I.start_seen;
        clr_c[B_START]    = CLR_I.combined_clr || off_c;
        // R6: stop seen
        set_c[B_STOP]     = EVT_I.stop_seen;
        clr_c[B_STOP]     = CLR_I.combined_clr || off_c;
        // R7: sticky activity capture
        set_c[B_ACTIVITY] = EVT_I.active;
        clr_c[B_ACTIVITY] = CLR_I.activity_clr || CLR_I.combined_clr || off_c;
        // R8: slave transmit finished by nack
        set_c[B_SLV_DONE] = EVT_I.slv_tx_nack;
        clr_c[B_SLV_DONE] = CLR_I.combined_clr || off_c;
        // R9: transmit abort
        set_c[B_TX_ABORT] = EVT_I.tx_abort;
        clr_c[B_TX_ABORT] = CLR_I.abort_clr || CLR_I.combined_clr;
        // R11: read request
        set_c[B_RD_REQ]   = EVT_I.rd_req;
        // R13: read request clear
        clr_c[B_RD_REQ]   = CLR_I.rd_req_clr || CLR_I.combined_clr || off_c;
        // R14: tx level at or below threshold; R15: disabled follows activity
        set_c[B_TX_EMPTY] = CTRL_ENABLED_I ? tx_low_c : FSM_ACTIVE_I;
        clr_c[B_TX_EMPTY] = !set_c[B_TX_EMPTY];
        // R16: write to a full transmit buffer
        set_c[B_TX_OVER]  = EVT_I.dc_write && tx_full_c;
        clr_c[B_TX_OVER]  = CLR_I.combined_clr || off_idle_c;
        // R17: rx level at or above threshold, dropped on disable
        set_c[B_RX_FULL]  = CTRL_ENABLED_I && rx_high_c;
        clr_c[B_RX_FULL]  = !set_c[B_RX_FULL];
        // R18: byte into a full receive buffer
        set_c[B_RX_OVER]  = EVT_I.rx_push && rx_full_c;
        clr_c[B_RX_OVER]  = CLR_I.combined_clr || off_idle_c;
        // R19: read of an empty receive buffer
        set_c[B_RX_UNDER] = EVT_I.dc_read && (RX_LEVEL_I == '0);
        clr_c[B_RX_UNDER] = CLR_I.combined_clr || off_idle_c;
    end

    // one registered flag per status bit
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        iim_flag u_flag (
            .clk_i   (CLK_I),
            .rst_b_i (RST_B_I),
            .set_i   (set_c[i]),
            .clr_i   (clr_c[i]),
            .q_o     (raw[i])
        );
    end

    // clock stretch until the processor supplies the byte
    always_comb begin
        hold_d = hold_q;
        if (EVT_I.rd_req) begin
            hold_d = 1'b1;
        end else if (EVT_I.dc_write || off_c) begin
            hold_d = 1'b0;
        end
    end

    // mask writes and register reads
    always_comb begin
        mask_d  = mask_q;
        rdata_d = rdata_q;
        if (REG_WR_I && REG_ADDR_I == MASK_ADDR) begin
            // R1: reserved bits stay zero
            mask_d = REG_WDATA_I & MASK_WBITS;
        end
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                MASK_ADDR: rdata_d = mask_q;
                RAW_ADDR:  rdata_d = {{(DATA_W - NUM_FLAGS){1'b0}}, raw};
                default:   rdata_d = RDATA_RST;
            endcase
        end
    end

    // register state
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mask_q  <= MASK_RST;
            rdata_q <= RDATA_RST;
            hold_q  <= 1'b0;
        end else begin
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
            hold_q  <= hold_d;
        end
    end

    // R1: mask gating; R20: single request line
    assign RAW_STATUS_O    = raw;
    assign MASKED_STATUS_O = raw & mask_q[NUM_FLAGS-1:0];
    assign IRQ_O           = |MASKED_STATUS_O;
    assign REG_RDATA_O     = rdata_q;
    // R11: hold clock low; R12: released by the processor's write
    assign SCL_HOLD_LOW_O  = hold_q;
    // R10: flush while aborted; R15: flush while disabled
    assign TX_FLUSH_O      = raw[B_TX_ABORT] || off_c;
    // writes into a flushed or full buffer are dropped
    assign TX_WRITE_O      = EVT_I.dc_write && !tx_full_c && !TX_FLUSH_O;
    // R4: general call data stored; R18: overflow byte dropped
    assign RX_WRITE_O      = EVT_I.rx_push && !rx_full_c && CTRL_ENABLED_I;

    // checks
    sequence s_abort_seen;
        EVT_I.tx_abort ##1 raw[B_TX_ABORT];
    endsequence
    sequence s_flushed_two;
        TX_FLUSH_O [*2];
    endsequence

    property p_mask_gate;
        @(posedge CLK_I) disable iff (!RST_B_I)
        $rose(mask_q[B_START]) && raw[B_START] |-> MASKED_STATUS_O[B_START] && IRQ_O;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("mask gate wrong"); // R1

    property p_bcast_set;
        @(posedge CLK_I) disable iff (!RST_B_I)
        EVT_I.bcast_ack |=> raw[B_BCAST];
    endproperty
    a_bcast_set: assert property (p_bcast_set) else $error("bcast not set"); // R2

    // nothing but an acknowledged general call may raise the flag
    property p_bcast_only;
        @(posedge CLK_I) disable iff (!RST_B_I)
        $rose(raw[B_BCAST]) |-> $past(EVT_I.bcast_ack);
    endproperty
    a_bcast_only: assert property (p_bcast_only) else $error("bcast set without ack"); // R2

    property p_bcast_keep;
        @(posedge CLK_I) disable iff (!RST_B_I)
        raw[B_BCAST] && CTRL_ENABLED_I && !CLR_I.broadcast_clr && !CLR_I.combined_clr
        |=> raw[B_BCAST];
    endproperty
    a_bcast_keep: assert property (p_bcast_keep) else $error("bcast lost"); // R3

    property p_start_stop;
        @(posedge CLK_I) disable iff (!RST_B_I)
        EVT_I.start_seen && EVT_I.stop_seen |=> raw[B_START] && raw[B_STOP];
    endproperty
    a_start_stop: assert property (p_start_stop) else $error("start/stop lost"); // R5

    property p_act_keep;
        @(posedge CLK_I) disable iff (!RST_B_I)
        raw[B_ACTIVITY] && CTRL_ENABLED_I && !CLR_I.activity_clr && !CLR_I.combined_clr
        |=> raw[B_ACTIVITY];
    endproperty
    a_act_keep: assert property (p_act_keep) else $error("activity lost"); // R7

    property p_abort_flush;
        @(posedge CLK_I) disable iff (!RST_B_I)
        // a clear read may legally come at any time, so only the cycles
        // known to be free of one are held to a flush
        s_abort_seen ##0 (!CLR_I.abort_clr && !CLR_I.combined_clr)
        ##1 (!CLR_I.abort_clr && !CLR_I.combined_clr) |-> s_flushed_two;
    endproperty
    a_abort_flush: assert property (p_abort_flush) else $error("no flush"); // R10

    property p_rd_hold;
        @(posedge CLK_I) disable iff (!RST_B_I)
        EVT_I.rd_req |=> SCL_HOLD_LOW_O && raw[B_RD_REQ];
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("no clock hold"); // R11

    property p_rd_clr;
        @(posedge CLK_I) disable iff (!RST_B_I)
        CLR_I.rd_req_clr && !EVT_I.rd_req |=> !raw[B_RD_REQ];
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("rd req not cleared"); // R13

    property p_tx_empty;
        @(posedge CLK_I) disable iff (!RST_B_I)
        CTRL_ENABLED_I && (TX_LEVEL_I <= tx_thr_c) |=> raw[B_TX_EMPTY];
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("tx empty wrong"); // R14

    property p_rx_full_off;
        @(posedge CLK_I) disable iff (!RST_B_I)
        !CTRL_ENABLED_I |=> !raw[B_RX_FULL];
    endproperty
    a_rx_full_off: assert property (p_rx_full_off) else $error("rx full kept"); // R17

    property p_rx_over;
        @(posedge CLK_I) disable iff (!RST_B_I)
        EVT_I.rx_push && rx_full_c |-> !RX_WRITE_O ##1 raw[B_RX_OVER];
    endproperty
    a_rx_over: assert property (p_rx_over) else $error("rx over wrong"); // R18

    property p_rx_under;
        @(posedge CLK_I) disable iff (!RST_B_I)
        EVT_I.dc_read && RX_LEVEL_I == '0 |=> raw[B_RX_UNDER] && MASKED_STATUS_O[B_RX_UNDER]
        == mask_q[B_RX_UNDER];
    endproperty
    a_rx_under: assert property (p_rx_under) else $error("rx under wrong"); // R19

    property p_irq;
        @(posedge CLK_I) disable iff (!RST_B_I)
        IRQ_O == |(RAW_STATUS_O & mask_q[NUM_FLAGS-1:0]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch"); // R20
endmodule : iim_core
`default_nettype wire

// ---- sim/iim_far_end.sv ----
/*
 * iim_far_end: processor side of the block; it answers a slave read
 * request by writing the data-command register after a set wait.
 * assumes: one clock, events as one-cycle pulses as in iim_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
module iim_far_end (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             en_i,
    input  wire logic [3:0]       wait_i,
    input  wire logic             scl_hold_i,
    input  wire iim_pkg::iim_evt_s evt_i,
    output var  iim_pkg::iim_evt_s evt_o
);
    import iim_pkg::*;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       wr_q;
    logic       wr_d;

    always_comb begin
        cnt_d = cnt_q;
        wr_d  = 1'b0;
        if (en_i && scl_hold_i && !wr_q) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == wait_i) begin
                cnt_d = 4'h0;
                wr_d  = 1'b1;
            end
        end
    end

    // counter and write strobe flops
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 4'h0;
            wr_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wr_q  <= wr_d;
        end
    end

    // merge: bench events plus the service write, one cycle wide
    always_comb begin
        evt_o          = evt_i;
        evt_o.dc_write = evt_i.dc_write | wr_q;
    end
endmodule : iim_far_end
`default_nettype wire

// ---- sim/iim_tb.sv ----
/*
 * tb: self-checking bench of the interrupt mask and raw status block.
 * assumes: iim_pkg and iim_far_end compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import iim_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [31:0] addr = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] wdata = 16'h0;
    logic [15:0] rdata;
    iim_evt_s    evt = '0;
    iim_evt_s    evt_dut;
    iim_clr_s    clr = '0;
    logic        en = 1'b1;
    logic        fsm = 1'b0;
    logic [5:0]  tx_lvl = 6'h0a;
    logic [5:0]  rx_lvl = 6'h00;
    logic [4:0]  tx_thr = 5'h05;
    logic [4:0]  rx_thr = 5'h05;
    logic [11:0] raw;
    logic [11:0] msk;
    logic        irq, flush, tx_wr, rx_wr, hold;
    logic        svc_on = 1'b0;
    logic [3:0]  svc_wait = 4'h0;
    int          errors = 0;
    int          tests_run = 0;
    int          n;
    // event bit, raw bit and clear strobe of each sticky flag
    int          eb [7] = '{9, 8, 7, 6, 5, 4, 3};
    int          rb [7] = '{11, 10, 9, 8, 7, 6, 5};
    int          cb [7] = '{4, 2, 2, 3, 2, 1, 0};

    always #12.5 clk = ~clk;

    iim_core iim_core_inst (
        .CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .EVT_I(evt_dut), .CLR_I(clr), .CTRL_ENABLED_I(en), .FSM_ACTIVE_I(fsm),
        .TX_LEVEL_I(tx_lvl), .TX_THRESHOLD_I(tx_thr), .RX_LEVEL_I(rx_lvl),
        .RX_THRESHOLD_I(rx_thr), .RAW_STATUS_O(raw), .MASKED_STATUS_O(msk),
        .IRQ_O(irq), .TX_FLUSH_O(flush), .TX_WRITE_O(tx_wr),
        .RX_WRITE_O(rx_wr), .SCL_HOLD_LOW_O(hold));

    iim_far_end iim_far_end_inst (
        .clk_i(clk), .rst_b_i(rst_b), .en_i(svc_on), .wait_i(svc_wait),
        .scl_hold_i(hold), .evt_i(evt), .evt_o(evt_dut));

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask : reg_wr

    // read strobe for one cycle, data registered one cycle later
    task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp,
                          input string nm);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check(nm, rdata, exp);
    endtask : rd_chk

    // one-cycle event and clear strobes, raw settles at the next edge
    task automatic pulse(input iim_evt_s e, input iim_clr_s c);
        @(posedge clk);
        evt <= e;
        clr <= c;
        @(posedge clk);
        evt <= '0;
        clr <= '0;
        #1;
    endtask : pulse

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #50000;
        errors++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(MASK_ADDR, 16'h08ff, "mask_reset");
        rd_chk(RAW_ADDR, 16'h0000, "raw_reset");
        reg_wr(MASK_ADDR, 16'hffff);
        reg_wr(RAW_ADDR, 16'h0fff);
        reg_wr(32'h5000_1338, 16'h0000);
        rd_chk(MASK_ADDR, 16'h0fff, "mask_reserved");
        rd_chk(RAW_ADDR, 16'h0000, "raw_read_only");
        rd_chk(32'h5000_1338, 16'h0000, "unmapped_read");
        $display("test registers done");
        // sticky flags set, stay and clear by their own strobe; start, stop and slave done clear by the combined strobe
        for (int i = 0; i < 7; i++) begin
            pulse(iim_evt_s'(10'(1) << eb[i]), '0);
            check("raw_set", raw, 12'(1) << rb[i]);
            check("masked_set", msk, 12'(1) << rb[i]);
            check("irq_set", irq, 1'b1);
            tick(2);
            check("raw_sticky", raw, 12'(1) << rb[i]);
            pulse('0, iim_clr_s'(5'(1) << cb[i]));
            check("raw_clear", raw, 12'h000);
        end
        $display("test sticky flags done");
        // start and stop in one cycle both land, one combined read clears
        pulse(iim_evt_s'(10'h180), '0);
        check("raw_start_stop", raw, 12'h600);
        pulse('0, iim_clr_s'(5'h04));
        check("raw_combined_clear", raw, 12'h000);
        pulse(iim_evt_s'(10'h100), '0);
        reg_wr(MASK_ADDR, 16'h0bff);
        check("masked_off", msk, 12'h000);
        check("irq_off", irq, 1'b0);
        reg_wr(MASK_ADDR, 16'h0400);
        check("masked_on", msk, 12'h400);
        check("irq_on", irq, 1'b1);
        $display("test mask gating done");
        // disable clears most flags, abort keeps the buffer flushed
        pulse(iim_evt_s'(10'h250), '0);
        @(posedge clk);
        en  <= 1'b0;
        fsm <= 1'b1;
        tick(2);
        check("raw_disabled", raw, 12'h050);
        check("flush_disabled", flush, 1'b1);
        check("hold_disabled", hold, 1'b0);
        @(posedge clk);
        fsm <= 1'b0;
        tick(2);
        check("raw_idle", raw, 12'h040);
        @(posedge clk);
        en <= 1'b1;
        tick(2);
        check("flush_abort", flush, 1'b1);
        @(posedge clk);
        evt <= iim_evt_s'(10'h002);
        #1 check("tx_write_flushed", tx_wr, 1'b0);
        pulse('0, iim_clr_s'(5'h02));
        check("raw_abort_clear", raw, 12'h000);
        check("flush_released", flush, 1'b0);
        @(posedge clk);
        evt <= iim_evt_s'(10'h002);
        #1 check("tx_write_open", tx_wr, 1'b1);
        $display("test disable and abort done");
        // read request answered promptly, then slowly
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            evt      <= '0;
            svc_on   <= 1'b1;
            svc_wait <= k ? 4'h3 : 4'h0;
            pulse(iim_evt_s'(10'h008), '0);
            check("hold_set", hold, 1'b1);
            n = 0;
            while (hold === 1'b1 && n < 50) begin
                tick(1);
                n++;
            end
            check("hold_cycles", 16'(n), 16'(svc_wait) + 16'd2);
            check("raw_rd_req_kept", raw, 12'h020);
            pulse('0, iim_clr_s'(5'h01));
            check("raw_rd_req_clear", raw, 12'h000);
        end
        $display("test read request done");
        // full, empty and threshold flags of the buffers
        @(posedge clk);
        tx_lvl <= 6'd32;
        rx_lvl <= 6'd32;
        fsm    <= 1'b1;
        tick(2);
        @(posedge clk);
        evt <= iim_evt_s'(10'h006);
        #1 check("tx_write_full", tx_wr, 1'b0);
        check("rx_write_full", rx_wr, 1'b0);
        @(posedge clk);
        evt <= '0;
        #1 check("raw_over", raw, 12'h00e);
        @(posedge clk);
        rx_lvl <= 6'd0;
        pulse(iim_evt_s'(10'h001), '0);
        check("raw_under", raw, 12'h00b);
        @(posedge clk);
        en <= 1'b0;
        tick(2);
        check("raw_off_busy", raw, 12'h01b);
        @(posedge clk);
        fsm <= 1'b0;
        tick(2);
        check("raw_off_idle", raw, 12'h000);
        @(posedge clk);
        en     <= 1'b1;
        tx_lvl <= 6'd5;
        rx_lvl <= 6'd6;
        tick(2);
        check("raw_at_threshold", raw, 12'h014);
        @(posedge clk);
        tx_lvl <= 6'd6;
        rx_lvl <= 6'd5;
        tick(2);
        check("raw_past_threshold", raw, 12'h000);
        pulse(iim_evt_s'(10'h200), '0);
        @(posedge clk);
        evt <= iim_evt_s'(10'h004);
        #1 check("rx_write_bcast", rx_wr, 1'b1);
        @(posedge clk);
        evt <= '0;
        $display("test buffer flags done");
        tick(2);
        complete_run();
    end
endmodule : tb
`default_nettype wire
